// File: hdl/tms_pkg.sv
// constants and bus map of the test-message sequencer
// assumes one 250 MHz clock and an asynchronous active-low reset
`default_nettype none
package tms_pkg;
   localparam int CNT_W = 6;
   localparam int ADDR_W = 8;
   localparam int LOW_W = 5;
   localparam int LOW_CLR_W = 4;
   localparam logic [CNT_W-1:0] CNT_TERMINAL = 6'h3f;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [1:0] CTRL_FN_LOW = 2'h0;
   // fast auxiliary clock for flushing the counter in Morse mode
   localparam int CLK_PERIOD_PS = 4000;
   localparam int AUX_PERIOD_NS = 40;
   localparam int AUX_CYCLES = (AUX_PERIOD_NS * 1000) / CLK_PERIOD_PS;
   localparam int AUX_W = 4;
   localparam logic [AUX_W-1:0] AUX_LAST = AUX_W'(AUX_CYCLES - 1);
   localparam logic [AUX_W-1:0] AUX_ZERO = 4'h0;
   // avalon-mm register map, byte addresses
   localparam int AVS_AW = 4;
   localparam logic [AVS_AW-1:0] REG_CTRL = 4'h0;
   localparam logic [AVS_AW-1:0] REG_STATUS = 4'h4;
   localparam logic [AVS_AW-1:0] REG_ADDR = 4'h8;
   localparam int CTRL_SW_KEY = 0;
   localparam int CTRL_HOLD = 1;
   localparam int ST_ACTIVE = 8;
   localparam int ST_LOCK = 9;
   localparam int ST_IDLE = 10;
   localparam int ST_PEND = 11;
   localparam int ST_MORSE = 12;
   localparam int ST_DONE_LSB = 16;
   localparam int DONE_W = 16;
   localparam logic [31:0] RDATA_ZERO = 32'h0;
endpackage
`default_nettype wire

// File: hdl/tms_sync.sv
// two-stage synchroniser for asynchronous level inputs
// assumes inputs come from pins outside the clock domain
`default_nettype none
module tms_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // level in and out
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } tms_sync_state_t;

   tms_sync_state_t st_q;
   tms_sync_state_t st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.meta = async_i;
      st_d.stable = st_q.meta;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= '{meta: RST_VAL, stable: RST_VAL};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.stable;
endmodule
`default_nettype wire

// File: hdl/tms_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes producer and consumer on the same clock
`default_nettype none
module tms_buf2 #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic [1:0] used;
      logic rd_idx;
      logic wr_idx;
   } tms_buf_state_t;

   tms_buf_state_t st_q;
   tms_buf_state_t st_d;
   logic push;
   logic pop;

   always_comb
   begin
      st_d = st_q;
      push = in_valid_i && (st_q.used != 2'h2);
      pop = out_ready_i && (st_q.used != 2'h0);
      if (push)
      begin
         st_d.mem[st_q.wr_idx] = in_data_i;
         st_d.wr_idx = ~st_q.wr_idx;
      end
      if (pop)
      begin
         st_d.rd_idx = ~st_q.rd_idx;
      end
      st_d.used = st_q.used + 2'(push) - 2'(pop);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign in_ready_o = (st_q.used != 2'h2);
   assign out_valid_o = (st_q.used != 2'h0);
   assign out_data_o = st_q.mem[st_q.rd_idx];
endmodule
`default_nettype wire

// File: hdl/tms_top.sv
// test-message sequencer with shared automatic-sequencer control
// assumes buffer control on the same board drives the resume pulse asynchronously;
// keyboard address, identifier and three-character status come from same-clock logic
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none
module tms_top
   import tms_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // pins from keyboard and buffer control
   input wire logic test_key_n_i,
   input wire logic mode_morse_i,
   input wire logic resume_pulse_n_i,
   // other automatic sequencers
   input wire logic others_idle_i,
   input wire logic ident_message_done_i,
   input wire logic three_group_active_i,
   // keyboard encoder address
   input wire logic [tms_pkg::ADDR_W-1:0] kbd_addr_i,
   // rom address and control lines
   output logic [tms_pkg::ADDR_W-1:0] rom_addr_o,
   output logic keyboard_lockout_o,
   output logic keyboard_encode_en_o,
   output logic sequencer_idle_o,
   output logic sequencer_step_o,
   output logic generator_active_o,
   // stream of message addresses
   output logic msg_valid_o,
   input wire logic msg_ready_i,
   output logic [tms_pkg::ADDR_W-1:0] msg_addr_o,
   // avalon-mm slave
   input wire logic [tms_pkg::AVS_AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);
   import tms_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic lock;
      logic idle;
      logic active;
      logic step;
      logic pend;
      logic resume_n;
      logic [ADDR_W-1:0] addr;
      logic kbd_en;
      logic [AUX_W-1:0] aux;
      logic sw_key;
      logic hold;
      logic waitreq;
      logic [31:0] rdata;
      logic [DONE_W-1:0] done_cnt;
      logic out_v;
      logic [ADDR_W-1:0] out_data;
   } tms_state_t;

   localparam tms_state_t ST_RST = '{
      cnt: CNT_TERMINAL,
      lock: 1'b0,
      idle: 1'b1,
      active: 1'b0,
      step: 1'b0,
      pend: 1'b0,
      resume_n: 1'b1,
      addr: '0,
      kbd_en: 1'b1,
      aux: AUX_ZERO,
      sw_key: 1'b0,
      hold: 1'b0,
      waitreq: 1'b1,
      rdata: RDATA_ZERO,
      done_cnt: '0,
      out_v: 1'b0,
      out_data: '0
   };

   tms_state_t st_q;
   tms_state_t st_d;

   logic key_n_s;
   logic morse_s;
   logic resume_n_s;
   logic gen_active;
   logic lockout;
   logic key_pressed;
   logic start_ok;
   logic clr_low;
   logic clr_high;
   logic resume_edge;
   logic aux_tick;
   logic flush;
   logic take;
   logic buf_in_ready;
   logic [CNT_W-1:0] cnt_next;
   logic req;
   logic wr_hit;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [ADDR_W-1:0] buf_out_data;

   // rom address as the generator presents it
   function automatic logic [ADDR_W-1:0] gen_addr(input logic [CNT_W-1:0] c);
      gen_addr = {c[CNT_W-1], CTRL_FN_LOW, c[LOW_W-1:0]};
   endfunction

   // active whenever the counter is off its terminal state
   function automatic logic is_active(input logic [CNT_W-1:0] c);
      is_active = (c != CNT_TERMINAL);
   endfunction

   // pins pass two stages before any logic sees them
   tms_sync #(
      .WIDTH(3),
      .RST_VAL(3'h5)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .async_i({test_key_n_i, mode_morse_i, resume_pulse_n_i}),
      .sync_o({key_n_s, morse_s, resume_n_s})
   );

   // message addresses wait here so a stalled receiver loses none
   tms_buf2 #(
      .WIDTH(ADDR_W)
   ) u_buf (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(take && !morse_s),
      .in_ready_o(buf_in_ready),
      .in_data_i(gen_addr(cnt_next)),
      .out_valid_o(buf_out_valid),
      .out_ready_i(buf_out_ready),
      .out_data_o(buf_out_data)
   );

   always_comb
   begin
      st_d = st_q;

      gen_active = is_active(st_q.cnt);
      // this generator, an unfinished ident message or the three-group sequencer holds the keyboard off; others_idle_i does not
      lockout = gen_active || !ident_message_done_i || three_group_active_i;

      // key is ignored in Morse mode; software key acts like the pin
      key_pressed = !key_n_s || st_q.sw_key;
      start_ok = key_pressed && !morse_s && st_q.idle && others_idle_i;
      clr_low = start_ok;
      clr_high = start_ok && !st_q.lock;

      // falling edge of resume is one step request
      resume_edge = st_q.resume_n && !resume_n_s;

      // fast auxiliary clock, only used to flush in Morse mode
      aux_tick = (st_q.aux == AUX_LAST);
      st_d.aux = aux_tick ? AUX_ZERO : st_q.aux + AUX_W'(1);
      flush = morse_s && gen_active && aux_tick;

      // step taken only while locked, running and the buffer has room, except a Morse-mode flush step
      take = (st_q.pend && st_q.lock && gen_active && !st_q.hold && buf_in_ready
              && !morse_s) || flush;
      cnt_next = st_q.cnt + CNT_ONE;

      st_d.resume_n = resume_n_s;
      // a new edge wins over the clear of the pending flag
      st_d.pend = (st_q.pend && !take) || (resume_edge && st_q.lock && gen_active);
      st_d.step = !resume_n_s && st_q.lock;

      if (clr_low)
      begin
         st_d.cnt[LOW_CLR_W-1:0] = '0;
         st_d.pend = 1'b0;
      end
      else if (take)
      begin
         st_d.cnt[LOW_CLR_W-1:0] = cnt_next[LOW_CLR_W-1:0];
      end
      if (clr_high || clr_low)
      begin
         st_d.cnt[CNT_W-1:LOW_CLR_W] = '0;
      end
      else if (take)
      begin
         // msb of the counter switches to the second region after 32 steps
         st_d.cnt[CNT_W-1:LOW_CLR_W] = cnt_next[CNT_W-1:LOW_CLR_W];
      end

      // count completed messages; at 63 steps the generator stops itself
      if (take && !flush && (cnt_next == CNT_TERMINAL))
      begin
         st_d.done_cnt = st_q.done_cnt + DONE_W'(1);
      end

      st_d.lock = lockout;
      // idle drops once lockout is up and the registered lock is up too
      st_d.idle = !(st_q.lock && lockout);
      // active follows the counter itself, not the shared idle line
      st_d.active = is_active(st_d.cnt);

      // address lines: generator owns all eight while active
      st_d.addr = gen_active ? gen_addr(st_q.cnt) : kbd_addr_i;
      st_d.kbd_en = !lockout;

      // output stage reloads whenever it is empty or being drained
      buf_out_ready = !st_q.out_v || msg_ready_i;
      if (buf_out_ready)
      begin
         st_d.out_v = buf_out_valid;
         st_d.out_data = buf_out_data;
      end

      // avalon slave: one wait state, then answer for a single cycle
      req = avs_read_i || avs_write_i;
      wr_hit = avs_write_i && !st_q.waitreq;
      st_d.waitreq = !(req && st_q.waitreq);
      if (req && st_q.waitreq)
      begin
         unique case (avs_address_i)
            REG_CTRL:
            begin
               st_d.rdata = RDATA_ZERO;
               st_d.rdata[CTRL_SW_KEY] = st_q.sw_key;
               st_d.rdata[CTRL_HOLD] = st_q.hold;
            end
            REG_STATUS:
            begin
               st_d.rdata = RDATA_ZERO;
               st_d.rdata[CNT_W-1:0] = st_q.cnt;
               st_d.rdata[ST_ACTIVE] = gen_active;
               st_d.rdata[ST_LOCK] = st_q.lock;
               st_d.rdata[ST_IDLE] = st_q.idle;
               st_d.rdata[ST_PEND] = st_q.pend;
               st_d.rdata[ST_MORSE] = morse_s;
               st_d.rdata[ST_DONE_LSB +: DONE_W] = st_q.done_cnt;
            end
            REG_ADDR:
            begin
               st_d.rdata = RDATA_ZERO;
               st_d.rdata[ADDR_W-1:0] = st_q.addr;
            end
            default:
            begin
               st_d.rdata = RDATA_ZERO;
            end
         endcase
      end
      if (wr_hit && (avs_address_i == REG_CTRL) && avs_byteenable_i[0])
      begin
         st_d.sw_key = avs_writedata_i[CTRL_SW_KEY];
         st_d.hold = avs_writedata_i[CTRL_HOLD];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= ST_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign rom_addr_o = st_q.addr;
   assign keyboard_lockout_o = st_q.lock;
   assign keyboard_encode_en_o = st_q.kbd_en;
   assign sequencer_idle_o = st_q.idle;
   assign sequencer_step_o = st_q.step;
   assign generator_active_o = st_q.active;
   assign msg_valid_o = st_q.out_v;
   assign msg_addr_o = st_q.out_data;
   assign avs_readdata_o = st_q.rdata;
   assign avs_waitrequest_o = st_q.waitreq;
endmodule
`default_nettype wire

// File: dv/tms_top_assertions.sv
// port checker for the test-message sequencer
// assumes it is bound onto tms_top; one clock domain
`default_nettype none
module tms_top_assertions
   import tms_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // watched ports
   input wire logic mode_morse_i,
   input wire logic three_group_active_i,
   input wire logic ident_message_done_i,
   input wire logic [tms_pkg::ADDR_W-1:0] kbd_addr_i,
   input wire logic [tms_pkg::ADDR_W-1:0] rom_addr_o,
   input wire logic keyboard_lockout_o,
   input wire logic keyboard_encode_en_o,
   input wire logic sequencer_idle_o,
   input wire logic sequencer_step_o,
   input wire logic generator_active_o,
   input wire logic msg_valid_o,
   input wire logic [tms_pkg::ADDR_W-1:0] msg_addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   a_ctrl_lines_low: assert property (
      generator_active_o && $past(generator_active_o) |-> rom_addr_o[6:5] == 2'h0)
      else $error("control address lines not low");
   a_msg_ctrl_low: assert property (
      msg_valid_o |-> msg_addr_o[6:5] == 2'h0) else $error("stream word control bits set");
   a_lock_others: assert property (
      three_group_active_i || !ident_message_done_i |=> keyboard_lockout_o)
      else $error("lockout missing for other sequencer");
   a_encode_inv: assert property (
      keyboard_encode_en_o == !keyboard_lockout_o) else $error("encoder enable wrong");
   a_active_idle: assert property (
      $rose(generator_active_o) |-> ##1 keyboard_lockout_o ##1 !sequencer_idle_o)
      else $error("active without lockout and idle drop");
   a_idle_after_lock: assert property (
      $fell(sequencer_idle_o) |-> keyboard_lockout_o && $past(keyboard_lockout_o))
      else $error("idle dropped before lockout");
   a_step_gated: assert property (
      sequencer_step_o |-> $past(keyboard_lockout_o)) else $error("step without lockout");
   a_kbd_pass: assert property (
      $past(rst_n_i, 2) && !keyboard_lockout_o && $past(!keyboard_lockout_o)
      |-> rom_addr_o == $past(kbd_addr_i)) else $error("keyboard address not passed");
   a_morse_ignore: assert property (
      (mode_morse_i && sequencer_idle_o && !keyboard_lockout_o && !three_group_active_i
      && ident_message_done_i)[*4] |=> !keyboard_lockout_o) else $error("start in morse");
endmodule
bind tms_top tms_top_assertions u_chk (.clk_sys_i, .rst_n_i, .mode_morse_i,
   .three_group_active_i, .ident_message_done_i, .kbd_addr_i, .rom_addr_o,
   .keyboard_lockout_o, .keyboard_encode_en_o, .sequencer_idle_o, .sequencer_step_o,
   .generator_active_o, .msg_valid_o, .msg_addr_o);
`default_nettype wire

// File: dv/tms_bc_model.sv
// buffer-control stand-in: resume pulses and message-stream acceptance
// assumes the sequencer clock; stall comes from the bench
`default_nettype none
module tms_bc_model (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // bench control
   input wire logic stall_i,
   // to the sequencer
   output logic resume_pulse_n_o,
   output logic msg_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] t_q;
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         t_q <= 4'h0;
         resume_pulse_n_o <= 1'b1;
         msg_ready_o <= 1'b0;
      end
      else
      begin
         t_q <= t_q + 4'h1;
         // one load per 16 cycles, resume low for two cycles after it
         resume_pulse_n_o <= !(t_q == 4'h2 || t_q == 4'h3);
         msg_ready_o <= !stall_i;
      end
   end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the test-message sequencer
// assumes tms_top, the buffer-control model and the bound checker
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tms_pkg::*;
   logic clk_sys_i = 0, rst_n_i = 0, test_key_n_i = 1, mode_morse_i = 0, resume_pulse_n_i;
   logic others_idle_i = 1, ident_message_done_i = 1, three_group_active_i = 0, msg_ready_i;
   logic [7:0] kbd_addr_i = 8'h8a, rom_addr_o, msg_addr_o;
   logic keyboard_lockout_o, keyboard_encode_en_o, sequencer_idle_o, sequencer_step_o;
   logic generator_active_o, msg_valid_o, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o;
   logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
   logic stall = 0;
   logic [7:0] q[$];
   int errors = 0, n_checks = 0, cyc = 0, n;
   tms_top u_dut (.clk_sys_i, .rst_n_i, .test_key_n_i, .mode_morse_i, .resume_pulse_n_i,
      .others_idle_i, .ident_message_done_i, .three_group_active_i, .kbd_addr_i, .rom_addr_o,
      .keyboard_lockout_o, .keyboard_encode_en_o, .sequencer_idle_o, .sequencer_step_o,
      .generator_active_o, .msg_valid_o, .msg_ready_i, .msg_addr_o, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o);
   tms_bc_model u_bc (.clk_sys_i, .rst_n_i, .stall_i(stall),
      .resume_pulse_n_o(resume_pulse_n_i), .msg_ready_o(msg_ready_i));
   initial forever #2 clk_sys_i = !clk_sys_i;
   always @(negedge clk_sys_i) if (msg_valid_o === 1'b1 && msg_ready_i === 1'b1)
      q.push_back(msg_addr_o);
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t %s seen %h exp %h", $time, m, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      avs_writedata_i <= wd;
      do
         @(posedge clk_sys_i);
      while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic wait_idle(input logic v, input int lim);
      repeat (lim) @(posedge clk_sys_i) if (sequencer_idle_o === v) break;
      chk(sequencer_idle_o, v, "idle wait");
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge clk_sys_i);
   endtask
   task automatic t_basic();
      chk({keyboard_lockout_o, keyboard_encode_en_o, sequencer_idle_o}, 3'h3, "rest");
      kbd_addr_i <= 8'h65;
      step(3);
      chk(rom_addr_o, 8'h65, "kbd pass");
      kbd_addr_i <= 8'h8a;
      three_group_active_i <= 1'b1;
      step(3);
      chk(keyboard_lockout_o, 1'b1, "group lock");
      three_group_active_i <= 1'b0;
      ident_message_done_i <= 1'b0;
      step(3);
      chk(keyboard_lockout_o, 1'b1, "ident lock");
      ident_message_done_i <= 1'b1;
      others_idle_i <= 1'b0;
      test_key_n_i <= 1'b0;
      step(20);
      chk({keyboard_lockout_o, sequencer_step_o}, 2'h0, "blocked");
      mode_morse_i <= 1'b1;
      step(3);
      others_idle_i <= 1'b1;
      step(20);
      chk(keyboard_lockout_o, 1'b0, "morse key");
      test_key_n_i <= 1'b1;
      mode_morse_i <= 1'b0;
      bus(1'b1, 4'hc, 32'h5);
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0, "unmapped");
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd[10:0], 11'h43f, "status rest");
      $display("basic done");
   endtask
   task automatic t_message();
      test_key_n_i <= 1'b0;
      wait_idle(1'b0, 20);
      chk(rom_addr_o, 8'h00, "first address");
      stall <= 1'b1;
      step(100);
      chk({msg_valid_o, q.size() <= 2}, 2'h3, "buffer full");
      stall <= 1'b0;
      wait_idle(1'b1, 2000);
      wait_idle(1'b0, 10);
      test_key_n_i <= 1'b1;
      wait_idle(1'b1, 2000);
      chk(q.size(), 126, "word count");
      for (int i = 0; i < 126; i++)
      begin
         n = i % 63 + 1;
         chk(q[i], {n[5], 2'h0, n[4:0]}, "message word");
      end
      bus(1'b0, REG_STATUS, 32'h0);
      chk({rd[31:16], rd[5:0]}, {16'h2, 6'h3f}, "status done");
      $display("message done");
   endtask
   task automatic t_flush();
      bus(1'b1, REG_CTRL, 32'h3);
      wait_idle(1'b0, 20);
      step(60);
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd[1:0], 2'h3, "ctrl readback");
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd[5:0], 6'h00, "hold stops steps");
      bus(1'b1, REG_CTRL, 32'h0);
      step(100);
      mode_morse_i <= 1'b1;
      step(20);
      n = q.size();
      wait_idle(1'b1, 1000);
      chk(q.size(), n, "no words in morse");
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd[5:0], 6'h3f, "flushed count");
      mode_morse_i <= 1'b0;
      $display("flush done");
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      step(3);
      rst_n_i <= 1'b1;
      step(2);
      t_basic();
      t_message();
      t_flush();
      final_report();
   end
endmodule
`default_nettype wire
